// *** hw/smc_map.svh ***
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH

// input vector layout: programmable, ground-referenced, battery-referenced
`define SMC_N_IN          12
`define SMC_N_PROG        4
`define SMC_N_GND         6
`define SMC_N_BATT        2
`define SMC_PROG_LO       0
`define SMC_GND_LO        4
`define SMC_BATT_LO       10

// serial word
`define SMC_WORD_W        16
`define SMC_BITCNT_W      5
`define SMC_CMD_RSVD_W    9

// reset values
`define SMC_CFG_RST       4'h0

// timing
`define SMC_CLK_PERIOD_NS 10
`define SMC_NS_PER_MS     1000000
`define SMC_POLL_MS       40
`define SMC_TIMER_MS      200
`define SMC_CNT_W         25

`endif

// *** hw/smc_pkg.sv ***
`include "smc_map.svh"

package smc_pkg;

  typedef enum logic [1:0] {
    SMC_SLEEP    = 2'h0,
    SMC_NORMAL   = 2'h1,
    SMC_POLL     = 2'h2,
    SMC_POLL_TMR = 2'h3
  } smc_mode_t;

  typedef logic [`SMC_N_IN-1:0]   smc_sw_t;
  typedef logic [`SMC_WORD_W-1:0] smc_word_t;

  // host to device, msb first
  typedef struct packed {
    smc_mode_t                  mode;
    logic [`SMC_N_PROG-1:0]     batt_ref;
    logic                       apply;
    logic [`SMC_CMD_RSVD_W-1:0] rsvd;
  } smc_cmd_t;

  // device to host, msb first
  typedef struct packed {
    logic      pend;
    logic      tmr_flag;
    smc_mode_t mode;
    smc_sw_t   sw;
  } smc_stat_t;

  typedef struct packed {
    smc_mode_t              mode;
    logic [`SMC_N_PROG-1:0] batt_ref;
    logic                   pend;
    logic                   tmr_flag;
    logic                   fresh;
    smc_sw_t                sw_stat;
    smc_sw_t                closed_prev;
    logic [`SMC_CNT_W-1:0]  poll_cnt;
    logic [`SMC_CNT_W-1:0]  tmr_cnt;
    smc_stat_t              snap;
    logic                   rx_tgl_prev;
    logic                   sync_in_prev;
    logic                   sync_out;
    logic                   irq_oe;
    logic                   irq_n_out;
    logic                   mon_en;
  } smc_core_st_t;

endpackage : smc_pkg

// *** hw/smc_sync.sv ***
`timescale 1ns/1ps

module smc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_b,
  // asynchronous in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } smc_sync_st_t;

  smc_sync_st_t st_q;
  smc_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule : smc_sync

// *** hw/smc_spi_link.sv ***
`timescale 1ns/1ps
`include "smc_map.svh"

module smc_spi_link (
  // link clock, frame and system reset
  input  wire logic                sclk,
  input  wire logic                chip_select_n,
  input  wire logic                rst_b,
  // serial data
  input  wire logic                si,
  output logic                     so_out,
  output logic                     so_oe,
  // words to and from the core
  input  wire smc_pkg::smc_word_t  tx_word,
  output smc_pkg::smc_word_t       rx_word,
  output logic                     rx_tgl
);

  localparam logic [`SMC_BITCNT_W-1:0] LAST_BIT = `SMC_BITCNT_W'(`SMC_WORD_W - 1);
  localparam logic [`SMC_BITCNT_W-1:0] ALL_BITS = `SMC_BITCNT_W'(`SMC_WORD_W);

  typedef struct packed {
    logic [`SMC_BITCNT_W-1:0] cnt;
    smc_pkg::smc_word_t       sh;
    logic                     so;
    logic                     oe;
  } smc_tx_st_t;

  typedef struct packed {
    logic [`SMC_BITCNT_W-1:0] cnt;
    smc_pkg::smc_word_t       sh;
  } smc_rx_st_t;

  smc_tx_st_t tx_q;
  smc_rx_st_t rx_q;
  logic       word_done;

  // status leaves on rising edges, host samples on falling edges
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      tx_q <= '0;
    end else if (tx_q.cnt == '0) begin
      tx_q.cnt <= tx_q.cnt + 1'b1;
      tx_q.so  <= tx_word[`SMC_WORD_W-1];
      tx_q.sh  <= {tx_word[`SMC_WORD_W-2:0], 1'b0};
      tx_q.oe  <= 1'b1;
    end else begin
      tx_q.cnt <= (tx_q.cnt == ALL_BITS) ? tx_q.cnt : tx_q.cnt + 1'b1;
      tx_q.so  <= tx_q.sh[`SMC_WORD_W-1];
      tx_q.sh  <= {tx_q.sh[`SMC_WORD_W-2:0], 1'b0};
    end
  end

  // command bits taken on falling edges; bits past the word are ignored
  always_ff @(negedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      rx_q <= '0;
    end else begin
      rx_q.sh  <= {rx_q.sh[`SMC_WORD_W-2:0], si};
      rx_q.cnt <= (rx_q.cnt == ALL_BITS) ? rx_q.cnt : rx_q.cnt + 1'b1;
    end
  end

  assign word_done = !chip_select_n && rx_q.cnt == LAST_BIT;

  // survives the frame; sclk is assumed still while rst_b is low
  always_ff @(negedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_word <= '0;
      rx_tgl  <= 1'b0;
    end else if (word_done) begin
      rx_word <= {rx_q.sh[`SMC_WORD_W-2:0], si};
      rx_tgl  <= ~rx_tgl;
    end
  end

  assign so_out = tx_q.so;
  assign so_oe  = tx_q.oe;

endmodule : smc_spi_link

// *** hw/smc_core.sv ***
`timescale 1ns/1ps
`include "smc_map.svh"

// Function
// - four modes sleep, normal, polling, polling with timer, chosen by serial command.
// - sleep stops monitoring and clears and blocks interrupts.
// - normal mode interrupts on any input changing open or closed.
// - polling samples periodically and interrupts only when a sample sees a closed input.
// - timer mode polls and also interrupts when the internal timer runs out.
// - the reset pin returns the device to sleep, the reset default.
// - a change on any monitored input wakes the device for an immediate sample.
// - four configurable, six ground and two battery inputs, all twelve monitored.
// - transfers only while chip select is low.
// - one bit in and one bit out per serial clock cycle: out on the rising edge, in on the falling edge.
// - interrupt pin is open drain, pulled low to assert, released otherwise.
// - master/slave pin picks whether the device sets or follows the poll timing.
// - sync output lets several devices wake and sample together.

module smc_core #(
  parameter int POLL_CYCLES  = (`SMC_POLL_MS * `SMC_NS_PER_MS) / `SMC_CLK_PERIOD_NS,
  parameter int TIMER_CYCLES = (`SMC_TIMER_MS * `SMC_NS_PER_MS) / `SMC_CLK_PERIOD_NS
) (
  // system
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  // serial link
  input  wire logic                    sclk,
  input  wire logic                    chip_select_n,
  input  wire logic                    si,
  output logic                         so_out,
  output logic                         so_oe,
  // device pins
  input  wire logic                    reset_n_in,
  input  wire logic                    master_slave_select,
  input  wire logic                    sync_in,
  input  wire logic [`SMC_N_PROG-1:0]  prog_input,
  input  wire logic [`SMC_N_GND-1:0]   gnd_switch_input,
  input  wire logic [`SMC_N_BATT-1:0]  batt_switch_input,
  // open-drain interrupt
  output logic                         irq_n_out,
  output logic                         irq_n_oe,
  // multi-device sync
  output logic                         sync_out,
  // analog front end controls
  output smc_pkg::smc_mode_t           mode_out,
  output logic [`SMC_N_PROG-1:0]       prog_batt_ref,
  output logic                         monitor_en
);

  localparam int CNT_W  = `SMC_CNT_W;
  localparam int SYNC_W = `SMC_N_IN + 5;

  smc_pkg::smc_core_st_t q;
  smc_pkg::smc_core_st_t n;
  smc_pkg::smc_word_t    rx_word;
  logic                  rx_tgl;
  logic [SYNC_W-1:0]     sync_raw;
  logic [SYNC_W-1:0]     sync_s;
  smc_pkg::smc_sw_t      sw_s;
  logic                  cs_s;
  logic                  rx_tgl_s;
  logic                  sync_in_s;
  logic                  master_s;
  logic                  pin_rst_s;
  smc_pkg::smc_sw_t      closed;
  smc_pkg::smc_cmd_t     cmd;
  logic                  rx_evt;
  logic                  changed;
  logic                  polling;
  logic                  poll_wrap;
  logic                  tmr_wrap;
  logic                  tick;
  logic                  sample;
  logic                  pend_set;

  // input pins as seen through the comparators: closed per reference
  function automatic smc_pkg::smc_sw_t smc_closed(
    input smc_pkg::smc_sw_t       lvl,
    input logic [`SMC_N_PROG-1:0] batt
  );
    smc_pkg::smc_sw_t c;
    c = ~lvl;
    c[`SMC_PROG_LO +: `SMC_N_PROG] = ~(lvl[`SMC_PROG_LO +: `SMC_N_PROG] ^ batt);
    c[`SMC_BATT_LO +: `SMC_N_BATT] = lvl[`SMC_BATT_LO +: `SMC_N_BATT];
    return c;
  endfunction : smc_closed

  smc_spi_link u_link (
    .sclk          (sclk),
    .chip_select_n (chip_select_n),
    .rst_b         (rst_b),
    .si            (si),
    .so_out        (so_out),
    .so_oe         (so_oe),
    .tx_word       (smc_pkg::smc_word_t'(q.snap)),
    .rx_word       (rx_word),
    .rx_tgl        (rx_tgl)
  );

  assign sync_raw = {chip_select_n, rx_tgl, sync_in, master_slave_select, reset_n_in,
                     batt_switch_input, gnd_switch_input, prog_input};

  smc_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     (sync_raw),
    .q     (sync_s)
  );

  assign sw_s      = sync_s[`SMC_N_IN-1:0];
  assign pin_rst_s = sync_s[`SMC_N_IN];
  assign master_s  = sync_s[`SMC_N_IN + 1];
  assign sync_in_s = sync_s[`SMC_N_IN + 2];
  assign rx_tgl_s  = sync_s[`SMC_N_IN + 3];
  assign cs_s      = sync_s[`SMC_N_IN + 4];

  always_comb begin
    n         = q;
    closed    = smc_closed(sw_s, q.batt_ref);
    cmd       = smc_pkg::smc_cmd_t'(rx_word);
    rx_evt    = rx_tgl_s ^ q.rx_tgl_prev;
    changed   = closed != q.closed_prev;
    polling   = q.mode == smc_pkg::SMC_POLL || q.mode == smc_pkg::SMC_POLL_TMR;
    poll_wrap = q.poll_cnt == CNT_W'(POLL_CYCLES - 1);
    tmr_wrap  = q.mode == smc_pkg::SMC_POLL_TMR && q.tmr_cnt == CNT_W'(TIMER_CYCLES - 1);
    // slaves take their poll moments from the master's sync edges
    tick      = master_s ? poll_wrap : (sync_in_s ^ q.sync_in_prev);
    sample    = polling && (tick || changed);
    pend_set  = (q.mode == smc_pkg::SMC_NORMAL && changed)
             || (sample && |closed)
             || tmr_wrap;

    n.rx_tgl_prev  = rx_tgl_s;
    n.sync_in_prev = sync_in_s;
    n.closed_prev  = closed;
    n.poll_cnt     = (polling && master_s && !poll_wrap) ? CNT_W'(q.poll_cnt + 1'b1) : '0;
    n.tmr_cnt      = (q.mode == smc_pkg::SMC_POLL_TMR && !tmr_wrap && !pend_set && !rx_evt) ?
                     CNT_W'(q.tmr_cnt + 1'b1) : '0;

    if (q.mode == smc_pkg::SMC_NORMAL || sample) begin
      n.sw_stat = closed;
    end

    // toggling rather than pulsing survives the slave's own clock
    if (!master_s) begin
      n.sync_out = 1'b0;
    end else if (sample) begin
      n.sync_out = ~q.sync_out;
    end

    // only what the host was shown is cleared; set wins over clear
    if (rx_evt && !q.fresh) begin
      n.pend     = 1'b0;
      n.tmr_flag = 1'b0;
    end
    if (pend_set) begin
      n.pend = 1'b1;
    end
    if (tmr_wrap) begin
      n.tmr_flag = 1'b1;
    end

    // snapshot frozen while framed; the link reads it as a quasi-static word
    if (!cs_s) begin
      n.fresh = q.fresh | pend_set;
    end else if (!rx_evt) begin
      n.fresh = pend_set;
      n.snap  = '{pend: q.pend, tmr_flag: q.tmr_flag, mode: q.mode, sw: q.sw_stat};
    end

    if (rx_evt && cmd.apply) begin
      n.mode     = cmd.mode;
      n.batt_ref = cmd.batt_ref;
    end
    if (!pin_rst_s) begin
      n.mode     = smc_pkg::SMC_SLEEP;
      n.batt_ref = `SMC_CFG_RST;
    end
    if (n.mode == smc_pkg::SMC_SLEEP) begin
      n.pend     = 1'b0;
      n.tmr_flag = 1'b0;
      n.fresh    = 1'b0;
      n.poll_cnt = '0;
      n.tmr_cnt  = '0;
    end

    n.irq_oe    = n.pend;
    n.irq_n_out = 1'b0;
    n.mon_en    = n.mode != smc_pkg::SMC_SLEEP;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= smc_pkg::smc_core_st_t'('0);
    end else begin
      q <= n;
    end
  end

  assign irq_n_out     = q.irq_n_out;
  assign irq_n_oe      = q.irq_oe;
  assign sync_out      = q.sync_out;
  assign mode_out      = q.mode;
  assign prog_batt_ref = q.batt_ref;
  assign monitor_en    = q.mon_en;

  // mode held over the next edge: no reset pin, no applied command
  logic hold_mode;
  assign hold_mode = pin_rst_s && !(rx_evt && cmd.apply);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_SLEEP_QUIET: assert property (
    mode_out == smc_pkg::SMC_SLEEP |-> !irq_n_oe && !monitor_en
  ) else $error("interrupt or monitoring active in sleep");

  AST_PIN_RESET_SLEEP: assert property (
    !pin_rst_s |=> mode_out == smc_pkg::SMC_SLEEP && !monitor_en
  ) else $error("reset pin did not force sleep");

  AST_CMD_MODE: assert property (
    rx_evt && cmd.apply && pin_rst_s |=> mode_out == $past(cmd.mode)
  ) else $error("applied command did not set mode");

  AST_NORMAL_CHANGE_IRQ: assert property (
    mode_out == smc_pkg::SMC_NORMAL && changed && hold_mode |=> irq_n_oe
  ) else $error("input change in normal mode raised no interrupt");

  AST_POLL_OPEN_QUIET: assert property (
    mode_out == smc_pkg::SMC_POLL && !irq_n_oe && closed == '0 |=> !irq_n_oe
  ) else $error("polling raised interrupt with all inputs open");

  AST_WAKE_CLOSED_IRQ: assert property (
    polling && changed && |closed && hold_mode |=> irq_n_oe && q.sw_stat == $past(closed)
  ) else $error("wake on change did not sample and interrupt");

  AST_TIMER_IRQ: assert property (
    tmr_wrap && hold_mode |=> irq_n_oe && q.tmr_flag
  ) else $error("timer expiry raised no interrupt");

  AST_READ_RELEASE: assert property (
    rx_evt && !q.fresh && !pend_set && irq_n_oe |=> !irq_n_oe
  ) else $error("status read did not release interrupt");

  AST_OPEN_DRAIN: assert property (
    irq_n_out == 1'b0 ##1 irq_n_oe == q.pend
  ) else $error("interrupt pad not driven as open drain low");

  AST_SLAVE_SYNC: assert property (
    !master_s |=> !sync_out
  ) else $error("slave drove sync output");

  AST_MASTER_SYNC: assert property (
    master_s && sample |=> sync_out != $past(sync_out)
  ) else $error("master sample did not toggle sync");

  AST_MON_EN: assert property (
    mode_out != smc_pkg::SMC_SLEEP |-> monitor_en
  ) else $error("monitoring off outside sleep");

  AST_CMD_BATT_REF: assert property (
    rx_evt && cmd.apply && pin_rst_s |=> prog_batt_ref == $past(cmd.batt_ref)
  ) else $error("applied command did not set input references");

  // the link reads the snapshot with no handshake of its own
  AST_SNAP_FROZEN: assert property (
    !cs_s |=> $stable(q.snap)
  ) else $error("status snapshot moved during a frame");

  AST_NORMAL_LIVE: assert property (
    mode_out == smc_pkg::SMC_NORMAL |=> q.sw_stat == $past(closed)
  ) else $error("normal mode status not live");

  AST_POLL_STATUS_HELD: assert property (
    polling && !sample |=> $stable(q.sw_stat)
  ) else $error("polling status moved between samples");

  AST_POLL_COUNT: assert property (
    polling && master_s && !poll_wrap && hold_mode |=> q.poll_cnt == CNT_W'($past(q.poll_cnt) + 1'b1)
  ) else $error("poll period counter did not advance");

  AST_TIMER_BOUND: assert property (
    q.tmr_cnt < CNT_W'(TIMER_CYCLES)
  ) else $error("interrupt timer ran past its length");

  AST_SLAVE_NO_COUNT: assert property (
    !master_s |=> q.poll_cnt == '0
  ) else $error("slave ran its own poll counter");

  AST_SLEEP_SYNC_HELD: assert property (
    mode_out == smc_pkg::SMC_SLEEP && master_s |=> $stable(sync_out)
  ) else $error("sync output moved in sleep");

  COV_NORMAL_IRQ: cover property (mode_out == smc_pkg::SMC_NORMAL && changed ##1 irq_n_oe);
  COV_POLL_CLOSED_IRQ: cover property (mode_out == smc_pkg::SMC_POLL && sample && |closed ##1 irq_n_oe);
  COV_TIMER_EXPIRY: cover property (tmr_wrap ##1 irq_n_oe);
  COV_READ_RELEASE: cover property (irq_n_oe && rx_evt ##1 !irq_n_oe);
  COV_SLAVE_TICK: cover property (!master_s && polling && tick);

endmodule : smc_core

// *** verif/smc_host_model.sv ***
`timescale 1ns/1ps
`include "smc_map.svh"

module smc_host_model (
  // spi master side
  output logic      chip_select_n,
  output logic      sclk,
  output logic      si,
  input  wire logic so
);
  localparam int HALF_NS = 80;

  initial begin
    chip_select_n = 1'h1;
    sclk          = 1'h0;
    si            = 1'h0;
  end

  // short frames only come from scenarios that expect them to be dropped
  task automatic xfer(input smc_pkg::smc_word_t cmd, input int nbits, output smc_pkg::smc_word_t stat);
    stat = '0;
    // odd start offset keeps the link phase unrelated to clk
    #37;
    chip_select_n = 1'h0;
    #HALF_NS;
    for (int i = 0; i < nbits; i++) begin
      sclk = 1'h1;
      si   = cmd[`SMC_WORD_W-1-i];
      #HALF_NS;
      sclk = 1'h0;
      stat = {stat[`SMC_WORD_W-2:0], so};
      #HALF_NS;
    end
    chip_select_n = 1'h1;
    // released data line must not keep showing the last bit
    si = ~si;
    #200;
  endtask : xfer
endmodule : smc_host_model

// *** verif/switch_monitor_mode_control_tb_top.sv ***
`timescale 1ns/1ps
`include "smc_map.svh"

module switch_monitor_mode_control_tb_top;
  localparam int POLL = 50;
  localparam int TMR  = 800;

  logic                   clk;
  logic                   rst_b;
  logic                   reset_n_in;
  logic                   master_slave_select;
  logic                   sync_in;
  logic                   sclk;
  logic                   chip_select_n;
  logic                   si;
  logic                   so_out;
  logic                   so_oe;
  logic                   irq_n_out;
  logic                   irq_n_oe;
  logic                   sync_out;
  logic                   monitor_en;
  smc_pkg::smc_mode_t     mode_out;
  logic [`SMC_N_PROG-1:0] prog_batt_ref;
  logic [`SMC_N_PROG-1:0] cfg_ref;
  smc_pkg::smc_sw_t       lv;
  smc_pkg::smc_word_t     stat;
  int                     miscompares;
  int                     samples_checked;
  wire                    so_w  = so_oe ? so_out : 1'bz;
  // pad pull-up on the open-drain pin
  wire                    irq_w = irq_n_oe ? irq_n_out : 1'h1;

  smc_core #(
    .POLL_CYCLES  (POLL),
    .TIMER_CYCLES (TMR)
  ) dut_u (
    .clk                 (clk),
    .rst_b               (rst_b),
    .sclk                (sclk),
    .chip_select_n       (chip_select_n),
    .si                  (si),
    .so_out              (so_out),
    .so_oe               (so_oe),
    .reset_n_in          (reset_n_in),
    .master_slave_select (master_slave_select),
    .sync_in             (sync_in),
    .prog_input          (lv[3:0]),
    .gnd_switch_input    (lv[9:4]),
    .batt_switch_input   (lv[11:10]),
    .irq_n_out           (irq_n_out),
    .irq_n_oe            (irq_n_oe),
    .sync_out            (sync_out),
    .mode_out            (mode_out),
    .prog_batt_ref       (prog_batt_ref),
    .monitor_en          (monitor_en)
  );

  smc_host_model host_u (
    .chip_select_n (chip_select_n),
    .sclk          (sclk),
    .si            (si),
    .so            (so_w)
  );

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp_bit(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %b exp %b", $time, msg, got, exp);
    end
  endtask : cmp_bit

  task automatic cmp_word(input smc_pkg::smc_word_t got, input smc_pkg::smc_word_t exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : cmp_word

  function automatic smc_pkg::smc_sw_t exp_sw();
    return {lv[11:10], ~lv[9:4], ~(lv[3:0] ^ cfg_ref)};
  endfunction : exp_sw

  function automatic smc_pkg::smc_word_t cfg_word();
    return {8'h0, prog_batt_ref, 2'h0, mode_out};
  endfunction : cfg_word

  task automatic wait_irq(input logic exp, input int bound);
    int n;
    for (n = 0; n < bound && irq_w !== exp; n++) @(negedge clk);
    cmp_bit(irq_w, exp, "irq wait");
    if (irq_w !== exp) print_verdict();
  endtask : wait_irq

  task automatic hold_irq(input logic exp, input int cyc);
    int n;
    for (n = 0; n < cyc && irq_w === exp; n++) @(negedge clk);
    cmp_bit(irq_w, exp, "irq hold");
  endtask : hold_irq

  task automatic spi(input smc_pkg::smc_mode_t m, input logic ap);
    host_u.xfer({m, cfg_ref, ap, 9'h0}, 16, stat);
    repeat (8) @(negedge clk);
  endtask : spi

  task automatic read_chk(input logic p, input logic t, input smc_pkg::smc_mode_t m);
    spi(m, 1'h0);
    cmp_word(stat, {p, t, m, exp_sw()}, "status");
  endtask : read_chk

  task automatic t_sleep;
    cmp_word(cfg_word(), 16'h0000, "reset cfg");
    cmp_bit(monitor_en, 1'h0, "mon_en");
    cmp_bit(so_oe, 1'h0, "so_oe");
    @(negedge clk);
    lv[5] = ~lv[5];
    hold_irq(1'h1, 20);
  endtask : t_sleep

  task automatic t_normal;
    cfg_ref = 4'hA;
    spi(smc_pkg::SMC_NORMAL, 1'h1);
    cmp_word(cfg_word(), 16'h00A1, "cfg");
    cmp_bit(monitor_en, 1'h1, "mon_en");
    spi(smc_pkg::SMC_NORMAL, 1'h0);
    wait_irq(1'h1, 10);
    // second lap turns every input back, covering both directions
    for (int i = 0; i < 2 * `SMC_N_IN; i++) begin
      @(negedge clk);
      lv[i % `SMC_N_IN] = ~lv[i % `SMC_N_IN];
      wait_irq(1'h0, 10);
      read_chk(1'h1, 1'h0, smc_pkg::SMC_NORMAL);
      wait_irq(1'h1, 10);
    end
    host_u.xfer({smc_pkg::SMC_POLL, 4'h5, 1'h1, 9'h0}, 8, stat);
    repeat (8) @(negedge clk);
    cmp_word(cfg_word(), 16'h00A1, "short frame");
  endtask : t_normal

  task automatic t_poll;
    logic s;
    @(negedge clk);
    lv = {2'h0, 6'h3F, ~cfg_ref};
    repeat (8) @(negedge clk);
    spi(smc_pkg::SMC_POLL, 1'h1);
    repeat (POLL) @(negedge clk);
    read_chk(1'h0, 1'h0, smc_pkg::SMC_POLL);
    s = sync_out;
    for (int n = 0; n < POLL + 10 && sync_out === s; n++) @(negedge clk);
    cmp_bit(sync_out, ~s, "sync toggle");
    if (sync_out === s) print_verdict();
    hold_irq(1'h1, 3 * POLL);
    @(negedge clk);
    master_slave_select = 1'h0;
    repeat (2 * POLL) @(negedge clk);
    cmp_bit(sync_out, 1'h0, "slave sync");
    lv[4] = 1'h0;
    wait_irq(1'h0, 10);
    read_chk(1'h1, 1'h0, smc_pkg::SMC_POLL);
    wait_irq(1'h1, 10);
    hold_irq(1'h1, 3 * POLL);
    sync_in = ~sync_in;
    wait_irq(1'h0, 10);
    read_chk(1'h1, 1'h0, smc_pkg::SMC_POLL);
    wait_irq(1'h1, 10);
    master_slave_select = 1'h1;
    wait_irq(1'h0, POLL + 10);
    @(negedge clk);
    lv[4] = 1'h1;
    repeat (10) @(negedge clk);
    read_chk(1'h1, 1'h0, smc_pkg::SMC_POLL);
    wait_irq(1'h1, 10);
    hold_irq(1'h1, 3 * POLL);
  endtask : t_poll

  task automatic t_timer;
    spi(smc_pkg::SMC_POLL_TMR, 1'h1);
    hold_irq(1'h1, TMR - 100);
    wait_irq(1'h0, 200);
    read_chk(1'h1, 1'h1, smc_pkg::SMC_POLL_TMR);
  endtask : t_timer

  task automatic t_rstpin;
    wait_irq(1'h0, TMR + 50);
    reset_n_in = 1'h0;
    repeat (4) @(negedge clk);
    cmp_word(cfg_word(), 16'h0000, "pin reset");
    cmp_bit(irq_w, 1'h1, "irq");
    cmp_bit(monitor_en, 1'h0, "mon_en");
    reset_n_in = 1'h1;
  endtask : t_rstpin

  initial begin
    rst_b               = 1'h0;
    reset_n_in          = 1'h1;
    master_slave_select = 1'h1;
    sync_in             = 1'h0;
    lv                  = 12'h000;
    cfg_ref             = 4'h0;
    miscompares         = 0;
    samples_checked     = 0;
    repeat (4) @(negedge clk);
    rst_b = 1'h1;
    repeat (4) @(negedge clk);
    t_sleep();
    t_normal();
    t_poll();
    t_timer();
    t_rstpin();
    print_verdict();
  end
endmodule : switch_monitor_mode_control_tb_top
